/* File: rtl/uhp_cfg_regs.sv */
/*
  Configuration register bank for the first host controller and the second host
  port with its USB 2.0 PHY, reached over AXI4-Lite.
  Assumes one clock, a synchronous active-low reset, and a line_state bus from
  the PHY that is asynchronous to aclk.
*/
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "uhp_defines.svh"

module uhp_cfg_regs (
  // Clock and reset
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // AXI4-Lite write address
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [`UHP_AW-1:0] s_axi_awaddr,
  input  wire logic [2:0]         s_axi_awprot,
  // AXI4-Lite write data
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  // AXI4-Lite write response
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  output logic [1:0]              s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  input  wire logic [`UHP_AW-1:0] s_axi_araddr,
  input  wire logic [2:0]         s_axi_arprot,
  // AXI4-Lite read data
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  // First host controller
  output logic                    first_port_burst4_enable,
  output logic                    first_port_burst16_enable,
  output logic                    first_port_hub_setup_minimum,
  output logic                    first_port_start_clock_request,
  output logic [5:0]              first_port_frame_adjust_shared,
  output logic [5:0]              first_port_frame_adjust,
  // Second host port: line state and interrupt
  input  wire logic [1:0]         line_state,
  output logic                    line_state_irq,
  // Second host PHY power and reset
  output logic                    analog_quiescent_test,
  output logic                    per_port_fsm_reset,
  output logic [2:0]              vbus_valid_threshold_code,
  output logic                    host_block_power_down,
  output logic [2:0]              disconnect_threshold_code,
  output logic                    common_block_power_n,
  // Second host PHY transmitter tuning
  output logic [1:0]              tx_edge_rate_code,
  output logic [1:0]              tx_crossover_code,
  output logic [3:0]              tx_dc_level_code,
  output logic [3:0]              full_low_speed_impedance_code,
  output logic                    pre_emphasis_duration_select,
  output logic [2:0]              squelch_threshold_code,
  // Second host PHY charging and sleep
  output logic                    charger_id_detect_enable,
  output logic                    data_contact_detect_enable,
  output logic [1:0]              source_impedance_code,
  output logic                    phy_sleep_n,
  output logic                    retention_n,
  output logic                    charge_source_voltage_enable,
  output logic                    charge_source_direction,
  output logic                    charge_attach_detect_enable,
  output logic [1:0]              pre_emphasis_amplitude_code
);

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  // One-hot register select: host0, pwr, tx, chg
  function automatic logic [3:0] reg_hit(input logic [`UHP_AW-1:0] addr);
    reg_hit[0] = {addr[`UHP_AW-1:2], 2'b00} == `UHP_OFS_HOST0;
    reg_hit[1] = {addr[`UHP_AW-1:2], 2'b00} == `UHP_OFS_PWR;
    reg_hit[2] = {addr[`UHP_AW-1:2], 2'b00} == `UHP_OFS_TX;
    reg_hit[3] = {addr[`UHP_AW-1:2], 2'b00} == `UHP_OFS_CHG;
  endfunction

  // Bit n changes only where its write-enable bit n+16 is set and both byte
  // lanes carrying the pair were strobed; reserved bits never change
  function automatic logic [15:0] merge(
    input logic [15:0] old,
    input logic [31:0] data,
    input logic [3:0]  strb,
    input logic [15:0] wmask
  );
    logic [15:0] res;
    res = old;
    for (int i = 0; i < 16; i++) begin
      if (data[`UHP_WE_LSB + i] && strb[2 + i / 8] && strb[i / 8] && wmask[i]) begin
        res[i] = data[i];
      end
    end
    return res;
  endfunction

  uhp_pkg::uhp_state_t s_q;
  uhp_pkg::uhp_state_t s_d;
  logic                ls_change;
  logic [3:0]          w_hit;
  logic [3:0]          r_hit;
  logic                w_commit;

  // ----------------------------------------------------------------------------
  // Line-state watcher
  // ----------------------------------------------------------------------------
  uhp_linestate_watch u_watch (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .line_state (line_state),
    .change     (ls_change)
  );

  // ----------------------------------------------------------------------------
  // Handshakes
  // ----------------------------------------------------------------------------
  // Each channel is held off while its slot is full or a response is pending
  assign s_axi_awready = !s_q.aw_have && (s_q.wst == uhp_pkg::UHP_W_IDLE);
  assign s_axi_wready  = !s_q.w_have && (s_q.wst == uhp_pkg::UHP_W_IDLE);
  assign s_axi_arready = !s_q.rvalid;
  assign w_hit         = reg_hit(s_q.aw_addr);
  assign r_hit         = reg_hit(s_axi_araddr);
  assign w_commit      = s_q.aw_have && s_q.w_have && (s_q.wst == uhp_pkg::UHP_W_IDLE);

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  // Register updates first, then the pending event, so a set beats a clear
  always_comb begin
    s_d = s_q;
    // Write address and data slots fill in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.aw_have = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.w_have = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    // Commit once both halves are present
    case (s_q.wst)
      uhp_pkg::UHP_W_IDLE: begin
        if (w_commit) begin
          if (w_hit[0]) begin
            s_d.host0 = merge(s_q.host0, s_q.w_data, s_q.w_strb, `UHP_WM_HOST0);
          end
          if (w_hit[1]) begin
            s_d.pwr = merge(s_q.pwr, s_q.w_data, s_q.w_strb, `UHP_WM_PWR);
          end
          if (w_hit[2]) begin
            s_d.tx = merge(s_q.tx, s_q.w_data, s_q.w_strb, `UHP_WM_TX);
          end
          if (w_hit[3]) begin
            s_d.chg = merge(s_q.chg, s_q.w_data, s_q.w_strb, `UHP_WM_CHG);
          end
          s_d.bresp   = (w_hit != 4'h0) ? `UHP_RESP_OKAY : `UHP_RESP_SLVERR;
          s_d.aw_have = 1'b0;
          s_d.w_have  = 1'b0;
          s_d.wst     = uhp_pkg::UHP_W_RESP;
        end
      end
      uhp_pkg::UHP_W_RESP: begin
        if (s_axi_bready) begin
          s_d.wst = uhp_pkg::UHP_W_IDLE;
        end
      end
      default: begin
        s_d.wst = uhp_pkg::UHP_W_IDLE;
      end
    endcase
    // A change seen in the same cycle as a software clear keeps the bit set
    if (ls_change) begin
      s_d.pwr[`UHP_PW_PEND] = 1'b1;
    end
    // Read data is captured once and held until taken
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = (r_hit != 4'h0) ? `UHP_RESP_OKAY : `UHP_RESP_SLVERR;
      // Write-enable half reads as zero; reserved bits are zero in storage
      s_d.rdata  = {16'h0000,
                    ({16{r_hit[0]}} & s_q.host0) |
                    ({16{r_hit[1]}} & s_q.pwr) |
                    ({16{r_hit[2]}} & s_q.tx) |
                    ({16{r_hit[3]}} & s_q.chg)};
    end
  end

  // ----------------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q       <= '0;
      s_q.host0 <= `UHP_RST_HOST0;
      s_q.pwr   <= `UHP_RST_PWR;
      s_q.tx    <= `UHP_RST_TX;
      s_q.chg   <= `UHP_RST_CHG;
      s_q.wst   <= uhp_pkg::UHP_W_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------------
  // Bus outputs
  // ----------------------------------------------------------------------------
  assign s_axi_bvalid = (s_q.wst == uhp_pkg::UHP_W_RESP);
  assign s_axi_bresp  = s_q.bresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata  = s_q.rdata;
  assign s_axi_rresp  = s_q.rresp;

  // ----------------------------------------------------------------------------
  // Controller and PHY outputs, all straight from flops except line_state_irq, an AND of two flops
  // ----------------------------------------------------------------------------
  // First host controller
  assign first_port_burst4_enable       = s_q.host0[`UHP_H0_BURST4];
  assign first_port_burst16_enable      = s_q.host0[`UHP_H0_BURST16];
  assign first_port_hub_setup_minimum   = s_q.host0[`UHP_H0_HUBMIN];
  assign first_port_start_clock_request = s_q.host0[`UHP_H0_STCLK];
  assign first_port_frame_adjust_shared = s_q.host0[11:6];
  assign first_port_frame_adjust        = s_q.host0[5:0];

  // Interrupt is a level, dropped as soon as either bit clears
  assign line_state_irq = s_q.pwr[`UHP_PW_PEND] && s_q.pwr[`UHP_PW_IRQEN];

  // Power and reset
  assign analog_quiescent_test     = s_q.pwr[`UHP_PW_IDDQ];
  assign per_port_fsm_reset        = s_q.pwr[`UHP_PW_PRST];
  assign vbus_valid_threshold_code = s_q.pwr[7:5];
  assign host_block_power_down     = s_q.pwr[`UHP_PW_HDIS];
  assign disconnect_threshold_code = s_q.pwr[3:1];
  assign common_block_power_n      = s_q.pwr[`UHP_PW_COMN];

  // Transmitter tuning; the reserved crossover code is passed on unchanged
  assign tx_edge_rate_code             = s_q.tx[15:14];
  assign tx_crossover_code             = s_q.tx[13:12];
  assign tx_dc_level_code              = s_q.tx[11:8];
  assign full_low_speed_impedance_code = s_q.tx[7:4];
  assign pre_emphasis_duration_select  = s_q.tx[`UHP_TX_PRESEL];
  assign squelch_threshold_code        = s_q.tx[2:0];

  // Charging, sleep and retention
  assign charger_id_detect_enable     = s_q.chg[`UHP_CH_ACA];
  assign data_contact_detect_enable   = s_q.chg[`UHP_CH_DCD];
  assign source_impedance_code        = s_q.chg[12:11];
  assign phy_sleep_n                  = s_q.chg[`UHP_CH_SLEEPN];
  assign retention_n                  = s_q.chg[`UHP_CH_RETN];
  assign charge_source_voltage_enable = s_q.chg[`UHP_CH_VSRC];
  assign charge_attach_detect_enable  = s_q.chg[`UHP_CH_VDET];
  assign charge_source_direction      = s_q.chg[`UHP_CH_DIR];
  assign pre_emphasis_amplitude_code  = s_q.chg[4:3];

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  AST_MASK_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    w_commit && (s_q.w_data[31:16] == 16'h0000) |=>
      $stable(s_q.host0) && $stable(s_q.tx) && $stable(s_q.chg))
    else $error("register changed under an all-zero write mask");

  AST_RST_HOST0: assert property (@(posedge aclk) disable iff (!aresetn)
    !$past(aresetn) |-> first_port_frame_adjust == 6'h20 && first_port_burst4_enable
      && first_port_burst16_enable && first_port_frame_adjust_shared == 6'h20)
    else $error("first host register reset value wrong");

  AST_RST_PWR: assert property (@(posedge aclk) disable iff (!aresetn)
    !$past(aresetn) |-> common_block_power_n && disconnect_threshold_code == 3'h4
      && !analog_quiescent_test && !host_block_power_down && !line_state_irq)
    else $error("power register reset value wrong");

  AST_RST_TX: assert property (@(posedge aclk) disable iff (!aresetn)
    !$past(aresetn) |-> tx_crossover_code == 2'h3 && tx_edge_rate_code == 2'h1
      && squelch_threshold_code == 3'h3 && !pre_emphasis_duration_select)
    else $error("tuning register reset value wrong");

  AST_RST_CHG: assert property (@(posedge aclk) disable iff (!aresetn)
    !$past(aresetn) |-> phy_sleep_n && retention_n && source_impedance_code == 2'h1
      && pre_emphasis_amplitude_code == 2'h1 && !charge_source_voltage_enable)
    else $error("charging register reset value wrong");

  AST_RESERVED_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && s_axi_rresp == `UHP_RESP_OKAY |->
      s_axi_rdata[31:16] == 16'h0000 && (s_q.chg[13] == 1'b0) && (s_q.chg[9] == 1'b0))
    else $error("reserved bits not zero");

  AST_PEND_SET_WINS: assert property (@(posedge aclk) disable iff (!aresetn)
    ls_change |=> s_q.pwr[`UHP_PW_PEND] ##1 (s_q.pwr[`UHP_PW_PEND] || $past(w_commit)))
    else $error("line-state change lost");

  AST_WRITE_ANSWER: assert property (@(posedge aclk) disable iff (!aresetn)
    w_commit |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
    else $error("write response not raised after commit");

  AST_READ_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before accepted");

  // Unmapped writes answer with an error and leave host0, tx and chg alone
  AST_UNMAPPED_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
    w_commit && (w_hit == 4'h0) |=>
      s_axi_bvalid && (s_axi_bresp == `UHP_RESP_SLVERR)
      && $stable(s_q.host0) && $stable(s_q.tx) && $stable(s_q.chg))
    else $error("unmapped write not refused");

  // Write data slot keeps its data on the next edge, though emptied, so it shows what landed
  AST_FULL_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
    w_commit && w_hit[2] && (s_q.w_strb == 4'hF) && (s_q.w_data[31:16] == 16'hFFFF) |=>
      s_q.tx == s_q.w_data[15:0])
    else $error("full-mask write did not land");

  // Software clear of pending takes effect when no new change races it
  AST_PEND_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
    w_commit && w_hit[1] && (s_q.w_strb == 4'hF) && s_q.w_data[`UHP_WE_LSB + `UHP_PW_PEND]
      && !s_q.w_data[`UHP_PW_PEND] && !ls_change |=> !s_q.pwr[`UHP_PW_PEND])
    else $error("pending bit not cleared by software");

  // Pending is sticky: only a register write can drop it
  AST_PEND_STICKY: assert property (@(posedge aclk) disable iff (!aresetn)
    s_q.pwr[`UHP_PW_PEND] && !w_commit |=> s_q.pwr[`UHP_PW_PEND])
    else $error("pending bit dropped without a write");

  // A taken read address is answered on the next edge, blocking another one
  AST_READ_ANSWER: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered one edge after address");

  // Unmapped reads return zero with an error response
  AST_READ_UNMAPPED: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && (r_hit == 4'h0) |=>
      (s_axi_rresp == `UHP_RESP_SLVERR) && (s_axi_rdata == 32'h0000_0000))
    else $error("unmapped read not refused");

endmodule

`default_nettype wire

/* File: rtl/uhp_defines.svh */
/*
  Offsets, field positions, reset values and write masks of the USB host and PHY
  configuration bank.
  Assumes a 12-bit byte address on the register bus and 32-bit data words.
*/
`ifndef UHP_DEFINES_SVH
`define UHP_DEFINES_SVH

// ----------------------------------------------------------------------------
// Bus geometry
// ----------------------------------------------------------------------------
`define UHP_AW          12
`define UHP_WE_LSB      16

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define UHP_OFS_HOST0   12'h344
`define UHP_OFS_PWR     12'h348
`define UHP_OFS_TX      12'h34C
`define UHP_OFS_CHG     12'h350

// ----------------------------------------------------------------------------
// Reset values and writable bits (reserved bits are never writable)
// ----------------------------------------------------------------------------
`define UHP_RST_HOST0   16'hC820
`define UHP_RST_PWR     16'h0089
`define UHP_RST_TX      16'h7333
`define UHP_RST_CHG     16'h0D08
`define UHP_WM_HOST0    16'hFFFF
`define UHP_WM_PWR      16'hF0FF
`define UHP_WM_TX       16'hFFFF
`define UHP_WM_CHG      16'hDDF8

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define UHP_H0_BURST4   15
`define UHP_H0_BURST16  14
`define UHP_H0_HUBMIN   13
`define UHP_H0_STCLK    12
`define UHP_PW_PEND     15
`define UHP_PW_IRQEN    14
`define UHP_PW_IDDQ     13
`define UHP_PW_PRST     12
`define UHP_PW_HDIS     4
`define UHP_PW_COMN     0
`define UHP_TX_PRESEL   3
`define UHP_CH_ACA      15
`define UHP_CH_DCD      14
`define UHP_CH_SLEEPN   10
`define UHP_CH_RETN     8
`define UHP_CH_VSRC     7
`define UHP_CH_VDET     6
`define UHP_CH_DIR      5

// ----------------------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------------------
`define UHP_RESP_OKAY   2'h0
`define UHP_RESP_SLVERR 2'h2

`endif

/* File: rtl/uhp_linestate_watch.sv */
/*
  Line-state change detector for the second host port.
  Assumes line_state arrives from the PHY clock domain and is quasi-static
  between changes, so a two-flop level synchroniser is enough.
*/
`timescale 1ns/1ps
`default_nettype none

module uhp_linestate_watch (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // PHY side
  input  wire logic [1:0] line_state,
  // Event out
  output logic            change
);

  uhp_pkg::uhp_watch_t s_q;
  uhp_pkg::uhp_watch_t s_d;

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  // Priming stops the reset value of the history from faking a first change
  always_comb begin
    s_d       = s_q;
    s_d.sync1 = line_state;
    s_d.sync2 = s_q.sync1;
    s_d.last  = s_q.sync2;
    if (s_q.prime != 2'h3) begin
      s_d.prime = s_q.prime + 2'h1;
    end
    s_d.change = (s_q.prime == 2'h3) && (s_q.sync2 != s_q.last);
  end

  // Single register stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign change = s_q.change;

  // A flagged change really was a change of the synchronised level
  AST_CHANGE_CAUSE: assert property (@(posedge aclk) disable iff (!aresetn)
    change |-> $past(s_q.sync2) != $past(s_q.last))
    else $error("line-state change flagged without a level change");

endmodule

`default_nettype wire

/* File: rtl/uhp_pkg.sv */
/*
  Types of the USB host and PHY configuration bank.
  Assumes uhp_defines.svh is on the include path.
*/
`include "uhp_defines.svh"

package uhp_pkg;

  // Write channel progress, one-hot
  typedef enum logic [1:0] {
    UHP_W_IDLE = 2'b01,
    UHP_W_RESP = 2'b10
  } uhp_wst_t;

  // Whole state of the register bank
  typedef struct packed {
    logic [15:0]         host0;
    logic [15:0]         pwr;
    logic [15:0]         tx;
    logic [15:0]         chg;
    logic                aw_have;
    logic [`UHP_AW-1:0]  aw_addr;
    logic                w_have;
    logic [31:0]         w_data;
    logic [3:0]          w_strb;
    uhp_wst_t            wst;
    logic [1:0]          bresp;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
  } uhp_state_t;

  // State of the line-state watcher
  typedef struct packed {
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] last;
    logic [1:0] prime;
    logic       change;
  } uhp_watch_t;

endpackage

/* File: test/tb_uhp_cfg_regs.sv */
/*
  Self-checking bench of the configuration bank over AXI4-Lite.
  Assumes the design files and uhp_phy_model are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_uhp_cfg_regs;
  localparam logic [11:0] OFS [4] = '{12'h344, 12'h348, 12'h34C, 12'h350};
  localparam logic [15:0] RST [4] = '{16'hC820, 16'h0089, 16'h7333, 16'h0D08};
  localparam logic [15:0] WM  [4] = '{16'hFFFF, 16'hF0FF, 16'hFFFF, 16'hDDF8};
  logic        aclk, aresetn, kick, s_axi_bready, s_axi_rready;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_arvalid;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [15:0] v [4];
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire         line_state_irq;
  wire [1:0]   s_axi_bresp, s_axi_rresp, line_state;
  wire [31:0]  s_axi_rdata;
  wire [15:0]  o0, o1, o2, o3;
  int          err_count, total_checks;
  // Bits with no pin behind them read as zero
  assign {o1[15:14], o1[11:8], o3[13], o3[9], o3[2:0]} = 11'h000;

  // Outputs land on register bit positions for direct comparison
  uhp_cfg_regs u_dut (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot(3'h0),
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
    .first_port_burst4_enable(o0[15]), .first_port_burst16_enable(o0[14]),
    .first_port_hub_setup_minimum(o0[13]), .first_port_start_clock_request(o0[12]),
    .first_port_frame_adjust_shared(o0[11:6]), .first_port_frame_adjust(o0[5:0]),
    .line_state, .line_state_irq, .analog_quiescent_test(o1[13]),
    .per_port_fsm_reset(o1[12]), .vbus_valid_threshold_code(o1[7:5]),
    .host_block_power_down(o1[4]), .disconnect_threshold_code(o1[3:1]),
    .common_block_power_n(o1[0]), .tx_edge_rate_code(o2[15:14]),
    .tx_crossover_code(o2[13:12]), .tx_dc_level_code(o2[11:8]),
    .full_low_speed_impedance_code(o2[7:4]), .pre_emphasis_duration_select(o2[3]),
    .squelch_threshold_code(o2[2:0]), .charger_id_detect_enable(o3[15]),
    .data_contact_detect_enable(o3[14]), .source_impedance_code(o3[12:11]),
    .phy_sleep_n(o3[10]), .retention_n(o3[8]), .charge_source_voltage_enable(o3[7]),
    .charge_attach_detect_enable(o3[6]), .charge_source_direction(o3[5]),
    .pre_emphasis_amplitude_code(o3[4:3])
  );
  uhp_phy_model u_phy (.aclk, .kick, .line_state);

  // ---------------------------------------------------------------------
  // Bus tasks
  // ---------------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  // Address and data offered together; ready lines stay high throughout
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) aw = 1'b1;
      if (s_axi_wready === 1'b1) w = 1'b1;
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    chk("bresp", s_axi_bresp, er);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    chk("rdata", s_axi_rdata, e);
    chk("rresp", s_axi_rresp, er);
  endtask
  // Read left waiting three cycles: the answer must stand until taken
  task automatic rd_held(input logic [11:0] a, input logic [31:0] e);
    s_axi_rready <= 1'b0;
    rd(a, e, 2'h0);
    repeat (3) @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    chk("held rdata", s_axi_rdata, e);
  endtask
  // Read back every register, then the pins it drives
  task automatic chkall;
    for (int i = 0; i < 4; i++) rd(OFS[i], {16'h0000, v[i]}, 2'h0);
    chk("host0 pins", o0, v[0]);
    chk("pwr pins", o1 & 16'h30FF, v[1] & 16'h30FF);
    chk("tx pins", o2, v[2]);
    chk("chg pins", o3 & 16'hDDF8, v[3]);
    chk("irq", line_state_irq, v[1][15] & v[1][14]);
  endtask
  // One line-state change, then time for the two-flop crossing
  task automatic bump;
    kick <= 1'b1;
    @(posedge aclk);
    kick <= 1'b0;
    repeat (8) @(posedge aclk);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ---------------------------------------------------------------------
  // Stimulus
  // ---------------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // Cuts a hang short well after the tests should have ended
  initial begin
    #1000000;
    err_count++;
    final_report;
  end
  initial begin
    {aresetn, kick, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
    {s_axi_bready, s_axi_rready} = 2'h3;
    err_count = 0;
    total_checks = 0;
    for (int i = 0; i < 4; i++) v[i] = RST[i];
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chkall;
    wr(OFS[1], 32'h4000_4000, 2'h0);
    v[1][14] = 1'b1;
    bump;
    v[1][15] = 1'b1;
    chkall;
    wr(OFS[1], 32'hC000_0000, 2'h0);
    v[1][15:14] = 2'h0;
    bump;
    v[1][15] = 1'b1;
    chkall;
    for (int i = 0; i < 4; i++) begin
      wr(OFS[i], {16'hFFFF, ~RST[i]}, 2'h0);
      v[i] = ~RST[i] & WM[i];
      wr(OFS[i], {16'h0000, RST[i]}, 2'h0);
      wr(OFS[i], 32'h5555_0000, 2'h0);
      v[i] = v[i] & ~16'h5555;
    end
    rd_held(OFS[2], {16'h0000, v[2]});
    chkall;
    wr(12'h354, 32'hFFFF_FFFF, 2'h2);
    rd(12'h354, 32'h0, 2'h2);
    chkall;
    final_report;
  end
endmodule

`default_nettype wire

/* File: test/uhp_phy_model.sv */
/*
  PHY line-state model for the configuration bank bench.
  Assumes the bench pulses kick for one cycle to request one line-state change.
*/
`timescale 1ns/1ps
`default_nettype none

module uhp_phy_model (
  // Clock
  input  wire logic       aclk,
  // Bench request for one change
  input  wire logic       kick,
  // Line state towards the bank
  output logic [1:0]      line_state
);
  // Steps the code so every request is a real change; held quasi-static after
  initial line_state = 2'h1;
  always @(posedge aclk) begin
    if (kick) line_state <= line_state + 2'h1;
  end
endmodule

`default_nettype wire
